// ===== sim/pat_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module pat_mem_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  input  wire logic [3:0]  slow,
  input  wire logic [15:0] fault_at,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata,
  output logic             mem_fault
);
  // Small store; the reserved destination range lies outside it
  logic [15:0] mem [0:255];
  logic [3:0]  wait_r;
  always_ff @(posedge aclk)
  begin
    mem_ack <= 1'h0;
    mem_fault <= 1'h0;
    // Lines wander between answers so a stale word is never read as fresh
    mem_rdata <= ~mem_rdata;
    if (!aresetn)
    begin
      wait_r <= 4'h0;
      mem_rdata <= 16'hA5A5;
    end
    else if (mem_rd && !mem_ack && wait_r < slow)
      wait_r <= wait_r + 4'h1;
    else if (mem_rd && !mem_ack)
    begin
      wait_r <= 4'h0;
      mem_ack <= 1'h1;
      mem_fault <= mem_addr == fault_at || mem_addr > 16'h00FF;
      mem_rdata <= mem[mem_addr[7:0]];
    end
  end
endmodule
`default_nettype wire

// ===== sim/pat_unit_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pat_unit_chk
  import pat_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              mem_rd,
  input wire logic [15:0]       mem_addr,
  input wire logic              mem_ack,
  input wire logic              mem_fault,
  input wire logic              irq
);
  // Saturates so a read long after the last command still counts as stray
  logic [9:0] aw_gap_r;
  always_ff @(posedge aclk)
    if (!aresetn)
      aw_gap_r <= 10'h3FF;
    else if (s_axi_awvalid && s_axi_awready)
      aw_gap_r <= 10'h000;
    else if (aw_gap_r != 10'h3FF)
      aw_gap_r <= aw_gap_r + 10'h001;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  run_needs_cmd_a: assert property ($rose(mem_rd) |-> aw_gap_r < 10'h190)
    else $error("table read with no command before it");
  addr_hold_a: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
    else $error("table read moved before its answer");
  word_order_a: assert property (mem_rd && mem_ack && !mem_fault
    |=> !mem_rd || mem_addr == $past(mem_addr) + 16'h0001)
    else $error("table words not read in order");
  fault_stops_a: assert property (mem_rd && mem_ack && mem_fault |=> !mem_rd [*3])
    else $error("table reads go on after a fault");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFF_IRQ_MASK
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  cover property (mem_rd && mem_ack && mem_fault);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cover property ($rose(irq));
endmodule
bind pat_unit pat_unit_chk chk_u (.*);
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pat_pkg::*;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, mem_rd, mem_ack, mem_fault, irq;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb, slow;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r, wresp;
  logic [15:0]       mem_addr, mem_rdata, fault_at, pres;
  int                miscompares = 0, checked = 0, seed = 71415, i;
  int                px[5] = '{0, 10, 20, 40, 50}, py[5] = '{100, 300, 251, 251, 0};
  pat_unit dut_u (.*);
  pat_mem_model mem_u (.*);
  initial
  begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  function automatic int b2i(input logic [15:0] v);
    return v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0];
  endfunction
  function automatic logic [15:0] i2b(input int v);
    return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction
  function automatic int fx(input int x, input int m);
    for (int k = 1; k <= m; k++)
      if (x <= px[k])
        return py[k-1] + (x - px[k-1]) * (py[k] - py[k-1]) / (px[k] - px[k-1]);
    return py[m];
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic stop();
    miscompares++;
    end_of_test();
  endtask
  // Ready is raised only after valid shows, so the slave's hold is exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit t = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (int n = 0; n < 99 && !t; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      t = s_axi_bvalid && s_axi_bready;
      s_axi_bready <= s_axi_bvalid && !t;
      wresp = s_axi_bresp;
    end
    if (!t) stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] p);
    bit t = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (int n = 0; n < 99 && !t; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      t = s_axi_rvalid && s_axi_rready;
      s_axi_rready <= s_axi_rvalid && !t;
      q = s_axi_rdata;
      p = s_axi_rresp;
    end
    if (!t) stop();
  endtask
  task automatic ex(input logic [16:0] op, input logic [15:0] s, input logic [15:0] e,
                    input logic er, input bit tol);
    logic [31:0] res, fl;
    int n, g;
    slow <= 4'($random(seed));
    wr(OFF_OPERAND, {15'h0000, op});
    wr(OFF_SOURCE, {16'h0000, s});
    wr(OFF_CTRL, 32'h0000_0001);
    fl = 32'h0000_0004;
    for (n = 0; n < 500 && fl[FLAG_BUSY_BIT] !== 1'h0; n++)
      rd(OFF_FLAGS, fl, r);
    if (n == 500) stop();
    rd(OFF_RESULT, res, r);
    if (er) e = pres;
    g = b2i(res[15:0]) - b2i(e);
    // The rotation engine may miss the last digit by one count
    if (tol && !$isunknown(res) && g * g <= 1) e = res[15:0];
    chk(res, {16'h0000, e});
    chk(fl, {30'h0, !er && e == 16'h0000, er});
    pres = e;
  endtask
  task automatic trig(input logic [15:0] c, input int a);
    int e;
    e = int'($floor($sin((c == CTRL_COS ? 900 - a : a) * 3.141592653589793 / 1800.0) * 1e4));
    ex({1'h0, c}, i2b(a), i2b(e > 9999 ? 9999 : e), 1'h0, 1'h1);
  endtask
  task automatic tab(input logic [15:0] h, input logic [15:0] s, input logic er);
    int x;
    mem_u.mem[16] = h;
    x = h[15] ? int'(s) : b2i(s);
    if (h[13]) x = x > 50 ? 0 : 50 - x;
    x = fx(x, h[7:0] + 1);
    ex({1'h1, 16'h0010}, s, h[14] ? 16'(x) : i2b(x), er, 1'h0);
  endtask
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, slow, pres} = '0;
    s_axi_wstrb = 4'hF;
    fault_at = 16'hFFFF;
    mem_u.mem[17] = 16'h0032;
    for (i = 0; i < 5; i++)
    begin
      mem_u.mem[18 + 2 * i] = 16'(py[i]);
      if (i > 0) mem_u.mem[17 + 2 * i] = 16'(px[i]);
    end
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    for (i = 0; i < 7; i++)
    begin
      rd(8'(4 * i), d, r);
      chk(d, 32'h0000_0000);
    end
    rd(8'h1C, d, r);
    chk(r, RESP_SLVERR);
    wr(8'h20, 32'h0000_0003);
    chk(wresp, RESP_SLVERR);
    wr(OFF_IRQ_MASK, 32'h0000_0003);
    trig(CTRL_SIN, 0);
    trig(CTRL_SIN, 300);
    trig(CTRL_SIN, 900);
    trig(CTRL_COS, 0);
    trig(CTRL_COS, 300);
    for (i = 0; i < 4; i++)
      trig(16'(i % 2), $unsigned($random(seed)) % 901);
    ex(17'h0_0000, 16'h0901, 16'h0000, 1'h1, 1'h0);
    ex(17'h0_0001, 16'h00A0, 16'h0000, 1'h1, 1'h0);
    ex(17'h0_FFFF, 16'h0100, 16'h0000, 1'h1, 1'h0);
    ex(17'h0_0002, 16'h0100, 16'h0000, 1'h1, 1'h0);
    chk(irq, 1'h1);
    rd(OFF_IRQ_STATUS, d, r);
    chk(d, 32'h0000_0003);
    rd(OFF_IRQ_STATUS, d, r);
    chk(d, 32'h0000_0000);
    chk(irq, 1'h0);
    wr(OFF_IRQ_MASK, 32'h0000_0002);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_SOURCE, 32'h0000_0500);
    rd(OFF_RESULT, d, r);
    chk(d, {16'h0000, pres});
    chk(irq, 1'h0);
    for (i = 0; i < 6; i++)
      tab(16'hC003, 16'($unsigned($random(seed)) % 61), 1'h0);
    chk(irq, 1'h0);
    tab(16'hC003, 16'h0000, 1'h0);
    tab(16'hC003, 16'h0032, 1'h0);
    tab(16'hC001, 16'h002D, 1'h0);
    tab(16'hE003, 16'h0005, 1'h0);
    tab(16'h4003, 16'h0015, 1'h0);
    tab(16'h8003, 16'h000F, 1'h0);
    tab(16'h4003, 16'h002A, 1'h1);
    fault_at = 16'h0013;
    tab(16'hC003, 16'h0005, 1'h1);
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== src/pat_div.sv
`timescale 1ns/10ps
`default_nettype none
module pat_div
  import pat_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  pat_div_if.server dv
);

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [31:0] quo;
    logic [16:0] rem;
    logic [15:0] den;
  } pat_div_st_t;

  pat_div_st_t r;
  pat_div_st_t n;

  always_comb
  begin
    logic [16:0] trial;
    trial = 17'h0_0000;
    n = r;
    n.done = 1'b0;
    if (!r.busy)
    begin
      // A start while busy is ignored; the client waits for done
      if (dv.start)
      begin
        n.busy = 1'b1;
        n.cnt = 6'h00;
        n.quo = dv.num;
        n.rem = 17'h0_0000;
        n.den = dv.den;
      end
    end
    else
    begin
      trial = {r.rem[15:0], r.quo[31]};
      n.quo = {r.quo[30:0], 1'b0};
      if (trial >= {1'b0, r.den})
      begin
        trial = trial - {1'b0, r.den};
        n.quo[0] = 1'b1;
      end
      n.rem = trial;
      n.cnt = r.cnt + 6'h01;
      if (n.cnt == DIV_STEPS)
      begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= n;
  end

  assign dv.done = r.done;
  assign dv.quo  = r.quo;
  assign dv.rem  = r.rem[15:0];

endmodule
`default_nettype wire

// ===== src/pat_div_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pat_div_if;
  logic        start;
  logic [31:0] num;
  logic [15:0] den;
  logic        done;
  logic [31:0] quo;
  logic [15:0] rem;
  modport client (output start, output num, output den, input done, input quo, input rem);
  modport server (input start, input num, input den, output done, output quo, output rem);
endinterface
`default_nettype wire

// ===== src/pat_pkg.sv
package pat_pkg;

  localparam int          AXI_AW         = 8;

  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_OPERAND    = 8'h04;
  localparam logic [7:0]  OFF_SOURCE     = 8'h08;
  localparam logic [7:0]  OFF_RESULT     = 8'h0C;
  localparam logic [7:0]  OFF_FLAGS      = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h18;

  // Field positions
  localparam int          CTRL_EXEC_BIT  = 0;
  localparam int          OPND_ADDR_BIT  = 16;
  localparam int          HDR_IN_BIN_BIT = 15;
  localparam int          HDR_OUT_BIN_BIT = 14;
  localparam int          HDR_MIRROR_BIT = 13;
  localparam int          FLAG_ERR_BIT   = 0;
  localparam int          FLAG_EQ_BIT    = 1;
  localparam int          FLAG_BUSY_BIT  = 2;
  localparam int          IRQ_DONE_BIT   = 0;
  localparam int          IRQ_ERR_BIT    = 1;

  // Reset values
  localparam logic [16:0] OPERAND_RST    = 17'h0_0000;
  localparam logic [15:0] SOURCE_RST     = 16'h0000;
  localparam logic [1:0]  IRQ_MASK_RST   = 2'h0;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // Control constants and limits
  localparam logic [15:0] CTRL_SIN       = 16'h0000;
  localparam logic [15:0] CTRL_COS       = 16'h0001;
  localparam logic [15:0] TRIG_MAX_BCD   = 16'h0900;
  localparam logic [15:0] BCD_MAX_BIN    = 16'h270F;
  localparam logic [15:0] TEN            = 16'h000A;

  // Rotation engine: angle unit is tenths of a degree times 256, values Q16
  localparam logic [4:0]  TRIG_LAST_ITER = 5'h0F;
  localparam logic [2:0]  LAST_DIGIT     = 3'h3;
  localparam logic signed [19:0] CORDIC_GAIN = 20'h0_9B75;
  localparam logic signed [19:0] TRIG_BIAS   = 20'h0_0002;
  localparam logic signed [19:0] Q16_MAX     = 20'h0_FFFF;
  localparam logic signed [19:0] ATAN_TBL [16] = '{
    20'h1_C200, 20'h1_09A7, 20'h0_8C5D, 20'h0_4740,
    20'h0_23C3, 20'h0_11E6, 20'h0_08F4, 20'h0_047A,
    20'h0_023D, 20'h0_011E, 20'h0_008F, 20'h0_0048,
    20'h0_0024, 20'h0_0012, 20'h0_0009, 20'h0_0004
  };

  localparam logic [5:0]  DIV_STEPS      = 6'h20;

  typedef enum logic [3:0] {
    ST_IDLE, ST_TRIG, ST_DIG, ST_HDR, ST_XM, ST_Y0, ST_XK, ST_YK, ST_DIV, ST_BCD
  } pat_state_t;

endpackage

// ===== src/pat_unit.sv
// Contract
// - Nothing happens unless executed; control operand then selects the computation
// - Control constant 0000 gives sine, 0001 cosine of BCD tenths of degrees
// - Error flag when trig input exceeds 0900
// - Error flag when control constant is neither 0000 nor 0001
// - Error flag when the approximation table cannot be read
// - Error flag on missing, non-BCD or out-of-area indirect memory word
// - Equals flag set when the result word is 0000
// - Trig result is four truncated BCD fraction digits, full scale 0.9999
// - Address control operand evaluates the stored piecewise-linear table at source x
// - Header bits 7..0 hold segment count minus one, binary
// - Header bit 15 input form, bit 14 output form; 1 means binary
// - Header bit 13 set mirrors the function left to right
// - Word C+1 max X, C+2 Y0, then X,Y pairs, all binary
// - First end-point X is implicitly 0000
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pat_unit
  import pat_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   mem_rd,
  output logic [15:0]            mem_addr,
  input  wire logic              mem_ack,
  input  wire logic [15:0]       mem_rdata,
  input  wire logic              mem_fault,
  output logic                   irq
);
  import pat_pkg::*;

  typedef struct packed {
    pat_state_t        state;
    logic              aw_got;
    logic              w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [16:0]       operand;
    logic [15:0]       source;
    logic [15:0]       result;
    logic              err;
    logic              eq;
    logic              busy;
    logic [1:0]        irq_st;
    logic [1:0]        irq_mask;
    logic              irq;
    logic              mem_rd;
    logic [15:0]       mem_addr;
    logic              is_cos;
    logic signed [19:0] cx;
    logic signed [19:0] cy;
    logic signed [19:0] cz;
    logic [4:0]        it;
    logic [15:0]       frac;
    logic              in_bin;
    logic              out_bin;
    logic              mirror;
    logic [7:0]        m_less1;
    logic [8:0]        k;
    logic [15:0]       xin;
    logic [15:0]       px;
    logic [15:0]       py;
    logic [15:0]       xk;
    logic              div_start;
    logic [31:0]       div_num;
    logic [15:0]       div_den;
    logic              neg;
    logic [15:0]       acc;
    logic [2:0]        dig;
  } pat_unit_st_t;

  pat_unit_st_t r;
  pat_unit_st_t n;

  pat_div_if dv ();

  pat_div u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .dv      (dv.server)
  );

  function automatic logic is_bcd(input logic [15:0] v);
    return (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v[11:8] <= 4'h9) && (v[15:12] <= 4'h9);
  endfunction

  function automatic logic [15:0] bcd2bin(input logic [15:0] v);
    return 16'(v[15:12] * 16'h03E8 + v[11:8] * 16'h0064 + v[7:4] * 16'h000A + v[3:0]);
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] o;
    o = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        o[i*8 +: 8] = d[i*8 +: 8];
    return o;
  endfunction

  always_comb
  begin
    logic              exec;
    logic              rd_clr;
    logic              fail;
    logic              fin;
    logic              emit;
    logic [15:0]       res;
    logic [15:0]       yval;
    logic              mem_ok;
    logic [15:0]       xs;
    logic [15:0]       dy;
    logic signed [19:0] v;
    logic [19:0]       t;
    logic [15:0]       cbase;
    exec = 1'b0;
    rd_clr = 1'b0;
    fail = 1'b0;
    fin = 1'b0;
    emit = 1'b0;
    res = 16'h0000;
    yval = 16'h0000;
    xs = 16'h0000;
    dy = 16'h0000;
    v = 20'h0_0000;
    t = 20'h0_0000;
    cbase = r.operand[15:0];
    mem_ok = r.mem_rd && mem_ack;
    n = r;
    n.div_start = 1'b0;

    // Write channel: address and data accepted in either order
    if (s_axi_awvalid && r.awready)
    begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready)
    begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    if (r.aw_got && r.w_got && !r.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (r.awaddr)
        OFF_CTRL:    exec = r.wstrb[0] && r.wdata[CTRL_EXEC_BIT];
        OFF_OPERAND: n.operand = 17'(wmerge({15'h0000, r.operand}, r.wdata, r.wstrb));
        OFF_SOURCE:  n.source = 16'(wmerge({16'h0000, r.source}, r.wdata, r.wstrb));
        OFF_IRQ_MASK: n.irq_mask = 2'(wmerge({30'h0, r.irq_mask}, r.wdata, r.wstrb));
        OFF_RESULT, OFF_FLAGS, OFF_IRQ_STATUS: n.bresp = RESP_OKAY;
        default:     n.bresp = RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    // Read channel
    if (r.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (s_axi_arvalid && r.arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        OFF_CTRL:       n.rdata = 32'h0000_0000;
        OFF_OPERAND:    n.rdata = {15'h0000, r.operand};
        OFF_SOURCE:     n.rdata = {16'h0000, r.source};
        OFF_RESULT:     n.rdata = {16'h0000, r.result};
        OFF_FLAGS:      n.rdata = {29'h0000_0000, r.busy, r.eq, r.err};
        OFF_IRQ_STATUS:
        begin
          n.rdata = {30'h0000_0000, r.irq_st};
          rd_clr = 1'b1;
        end
        OFF_IRQ_MASK:   n.rdata = {30'h0000_0000, r.irq_mask};
        default:        n.rresp = RESP_SLVERR;
      endcase
    end
    n.arready = !n.rvalid;

    if (mem_ok)
      n.mem_rd = 1'b0;
    if (mem_ok && mem_fault)
      fail = 1'b1;

    case (r.state)
      ST_IDLE:
        if (exec)
        begin
          n.busy = 1'b1;
          if (r.operand[OPND_ADDR_BIT])
          begin
            n.mem_rd = 1'b1;
            n.mem_addr = cbase;
            n.state = ST_HDR;
          end
          else if (cbase == CTRL_SIN || cbase == CTRL_COS)
          begin
            if (!is_bcd(r.source))
              fail = 1'b1;
            else if (r.source > TRIG_MAX_BCD)
              fail = 1'b1;
            else
            begin
              n.is_cos = (cbase == CTRL_COS);
              n.cx = CORDIC_GAIN;
              n.cy = 20'h0_0000;
              n.cz = 20'({bcd2bin(r.source), 8'h00});
              n.it = 5'h00;
              n.state = ST_TRIG;
            end
          end
          else
            fail = 1'b1;
        end
      ST_TRIG:
      begin
        if (r.cz >= 0)
        begin
          n.cx = r.cx - (r.cy >>> r.it);
          n.cy = r.cy + (r.cx >>> r.it);
          n.cz = r.cz - ATAN_TBL[r.it[3:0]];
        end
        else
        begin
          n.cx = r.cx + (r.cy >>> r.it);
          n.cy = r.cy - (r.cx >>> r.it);
          n.cz = r.cz + ATAN_TBL[r.it[3:0]];
        end
        if (r.it == TRIG_LAST_ITER)
        begin
          // Saturating at just under one makes full scale read 0.9999
          v = (r.is_cos ? n.cx : n.cy) + TRIG_BIAS;
          if (v < 0)
            n.frac = 16'h0000;
          else if (v > Q16_MAX)
            n.frac = 16'hFFFF;
          else
            n.frac = v[15:0];
          n.it = 5'h00;
          n.acc = 16'h0000;
          n.state = ST_DIG;
        end
        else
          n.it = r.it + 5'h01;
      end
      ST_DIG:
      begin
        // Digits are cut, never rounded
        t = {r.frac, 3'b000} + {3'b000, r.frac, 1'b0};
        n.frac = t[15:0];
        n.acc = {r.acc[11:0], t[19:16]};
        n.it = r.it + 5'h01;
        if (r.it[2:0] == LAST_DIGIT)
        begin
          fin = 1'b1;
          res = n.acc;
        end
      end
      ST_HDR:
        if (mem_ok && !mem_fault)
        begin
          n.in_bin = mem_rdata[HDR_IN_BIN_BIT];
          n.out_bin = mem_rdata[HDR_OUT_BIN_BIT];
          n.mirror = mem_rdata[HDR_MIRROR_BIT];
          n.m_less1 = mem_rdata[7:0];
          n.mem_rd = 1'b1;
          n.mem_addr = cbase + 16'h0001;
          n.state = ST_XM;
        end
      ST_XM:
        if (mem_ok && !mem_fault)
        begin
          xs = r.in_bin ? r.source : bcd2bin(r.source);
          if (!r.in_bin && !is_bcd(r.source))
            fail = 1'b1;
          else
          begin
            if (r.mirror)
              n.xin = (xs > mem_rdata) ? 16'h0000 : 16'(mem_rdata - xs);
            else
              n.xin = xs;
            n.mem_rd = 1'b1;
            n.mem_addr = cbase + 16'h0002;
            n.state = ST_Y0;
          end
        end
      ST_Y0:
        if (mem_ok && !mem_fault)
        begin
          n.py = mem_rdata;
          n.px = 16'h0000;
          n.k = 9'h001;
          n.mem_rd = 1'b1;
          n.mem_addr = cbase + 16'h0003;
          n.state = ST_XK;
        end
      ST_XK:
        if (mem_ok && !mem_fault)
        begin
          n.xk = mem_rdata;
          n.mem_rd = 1'b1;
          n.mem_addr = 16'(cbase + {6'h00, r.k, 1'b0} + 16'h0002);
          n.state = ST_YK;
        end
      ST_YK:
        if (mem_ok && !mem_fault)
        begin
          if (r.xin >= r.xk && r.k == {1'b0, r.m_less1} + 9'h001)
          begin
            // Beyond the last end-point the output holds at its Y
            emit = 1'b1;
            yval = mem_rdata;
          end
          else if (r.xin <= r.xk)
          begin
            if (r.xin == r.xk)
            begin
              emit = 1'b1;
              yval = mem_rdata;
            end
            else
            begin
              n.neg = mem_rdata < r.py;
              dy = n.neg ? 16'(r.py - mem_rdata) : 16'(mem_rdata - r.py);
              n.div_start = 1'b1;
              n.div_num = 32'(r.xin - r.px) * 32'(dy);
              n.div_den = 16'(r.xk - r.px);
              n.state = ST_DIV;
            end
          end
          else
          begin
            n.px = r.xk;
            n.py = mem_rdata;
            n.k = r.k + 9'h001;
            n.mem_rd = 1'b1;
            n.mem_addr = 16'(cbase + {6'h00, n.k, 1'b0} + 16'h0001);
            n.state = ST_XK;
          end
        end
      ST_DIV:
        if (dv.done)
        begin
          emit = 1'b1;
          yval = r.neg ? 16'(r.py - dv.quo[15:0]) : 16'(r.py + dv.quo[15:0]);
        end
      ST_BCD:
        if (dv.done)
        begin
          n.frac = {dv.rem[3:0], r.frac[15:4]};
          n.acc = dv.quo[15:0];
          n.dig = r.dig + 3'h1;
          if (r.dig == LAST_DIGIT)
          begin
            fin = 1'b1;
            res = n.frac;
          end
          else
          begin
            n.div_start = 1'b1;
            n.div_num = {16'h0000, dv.quo[15:0]};
            n.div_den = TEN;
          end
        end
      default: n.state = ST_IDLE;
    endcase

    if (emit)
    begin
      if (r.out_bin)
      begin
        fin = 1'b1;
        res = yval;
      end
      else if (yval > BCD_MAX_BIN)
        fail = 1'b1;
      else
      begin
        n.dig = 3'h0;
        n.frac = 16'h0000;
        n.div_start = 1'b1;
        n.div_num = {16'h0000, yval};
        n.div_den = TEN;
        n.state = ST_BCD;
      end
    end

    if (fail)
    begin
      n.err = 1'b1;
      n.eq = 1'b0;
      n.mem_rd = 1'b0;
      n.busy = 1'b0;
      n.state = ST_IDLE;
    end
    else if (fin)
    begin
      n.result = res;
      n.err = 1'b0;
      n.eq = (res == 16'h0000);
      n.busy = 1'b0;
      n.state = ST_IDLE;
    end

    // New events win over a read-clear in the same cycle
    n.irq_st = (r.irq_st & (rd_clr ? 2'b00 : 2'b11)) | {fail, fail || fin};
    n.irq = |(n.irq_st & n.irq_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.operand <= OPERAND_RST;
      r.source <= SOURCE_RST;
      r.irq_mask <= IRQ_MASK_RST;
    end
    else
      r <= n;
  end

  assign dv.start = r.div_start;
  assign dv.num   = r.div_num;
  assign dv.den   = r.div_den;

  assign s_axi_awready = r.awready;
  assign s_axi_wready  = r.wready;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign s_axi_rvalid  = r.rvalid;
  assign mem_rd        = r.mem_rd;
  assign mem_addr      = r.mem_addr;
  assign irq           = r.irq;

endmodule
`default_nettype wire
